// ---- hw/smsr_status_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "smsr_defines.svh"
module smsr_status_regs (
  input wire logic CLK,
  input wire logic NRST,
  // Register access from the serial port logic
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [5:0] REG_ADDR,
  output logic [23:0] REG_RDATA,
  output logic REG_RVALID,
  output logic REG_WACK,
  // Configuration word stream for the checksum
  input wire logic CFG_START,
  input wire logic CFG_VALID,
  input wire logic CFG_LAST,
  input wire logic [23:0] CFG_WORD,
  output logic CFG_READY,
  // Comparator mode selection per input, same clock domain
  input wire logic [23:0] COMP_SEL,
  // Analog monitor levels, asynchronous
  input wire logic ADC_DIAG_ERR,
  input wire logic [1:0] SINK_FAULT,
  input wire logic [1:0] SOURCE_FAULT,
  input wire logic WIN_A_ABOVE_LOW,
  input wire logic WIN_A_ABOVE_HIGH,
  input wire logic WIN_B_ABOVE_LOW,
  input wire logic WIN_B_ABOVE_HIGH,
  input wire logic UNDERVOLTAGE,
  input wire logic OVERVOLTAGE,
  input wire logic OVER_WARNING_TEMP,
  input wire logic OVER_SHUTDOWN_TEMP,
  input wire logic [23:0] COMP_ABOVE
);

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  // Bit order fixes the sync_q slices below
  wire [`SMSR_NUM_ASYNC-1:0] async_in = {
    COMP_ABOVE,
    OVER_SHUTDOWN_TEMP,
    OVER_WARNING_TEMP,
    OVERVOLTAGE,
    UNDERVOLTAGE,
    WIN_B_ABOVE_HIGH,
    WIN_B_ABOVE_LOW,
    WIN_A_ABOVE_HIGH,
    WIN_A_ABOVE_LOW,
    SOURCE_FAULT,
    SINK_FAULT,
    ADC_DIAG_ERR
  };
  logic [`SMSR_NUM_ASYNC-1:0] meta_q;
  logic [`SMSR_NUM_ASYNC-1:0] sync_q;

  genvar gi;
  generate
    for (gi = 0; gi < `SMSR_NUM_ASYNC; gi = gi + 1) begin : g_sync
      always_ff @(posedge CLK) begin
        if (!NRST) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire s_adc_diag = sync_q[0];
  wire [1:0] s_sink = sync_q[2:1];
  wire [1:0] s_source = sync_q[4:3];
  wire s_a_low = sync_q[5];
  wire s_a_high = sync_q[6];
  wire s_b_low = sync_q[7];
  wire s_b_high = sync_q[8];
  wire s_uv = sync_q[9];
  wire s_ov = sync_q[10];
  wire s_tw = sync_q[11];
  wire s_tsd = sync_q[12];
  wire [23:0] s_comp = sync_q[36:13];

  // --------------------------------------------------------------
  // Supply window encoding
  // --------------------------------------------------------------
  // R7: three-level window code
  wire [1:0] supply_window_b = s_b_high ? `SMSR_WIN_ABOVE : (s_b_low ? `SMSR_WIN_MID : `SMSR_WIN_BELOW);
  // R8: second window, own thresholds
  wire [1:0] supply_window_a = s_a_high ? `SMSR_WIN_ABOVE : (s_a_low ? `SMSR_WIN_MID : `SMSR_WIN_BELOW);

  // --------------------------------------------------------------
  // Misc status word
  // --------------------------------------------------------------
  logic [23:0] misc_d;
  always_comb begin
    misc_d = `SMSR_RST_MISC;
    // R4: converter diagnostic
    misc_d[`SMSR_BIT_ADC_DIAG] = s_adc_diag;
    // R5: sink health
    misc_d[`SMSR_BIT_SINK3] = s_sink[1];
    misc_d[`SMSR_BIT_SINK2] = s_sink[0];
    // R6: source health
    misc_d[`SMSR_BIT_SOURCE1] = s_source[1];
    misc_d[`SMSR_BIT_SOURCE0] = s_source[0];
    misc_d[`SMSR_POS_WIN_B +: 2] = supply_window_b;
    misc_d[`SMSR_POS_WIN_A +: 2] = supply_window_a;
    // R9: under-voltage level
    misc_d[`SMSR_BIT_UV] = s_uv;
    // R10: over-voltage level
    misc_d[`SMSR_BIT_OV] = s_ov;
    // R11: warning temperature level
    misc_d[`SMSR_BIT_TW] = s_tw;
    // R12: shutdown temperature level
    misc_d[`SMSR_BIT_TSD] = s_tsd;
  end

  // R13: only comparator-mode inputs report
  wire [23:0] comp_d = s_comp & COMP_SEL;

  // --------------------------------------------------------------
  // Live status registers
  // --------------------------------------------------------------
  logic [23:0] misc_device_status_q;
  logic [23:0] comparator_input_status_q;

  // R15: live copy every cycle, nothing latched
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      misc_device_status_q <= `SMSR_RST_MISC;
      comparator_input_status_q <= `SMSR_RST_COMP;
    end else begin
      misc_device_status_q <= misc_d;
      comparator_input_status_q <= comp_d;
    end
  end

  // --------------------------------------------------------------
  // Config stream handshake
  // --------------------------------------------------------------
  smsr_crc_if crc_bus ();

  logic cfg_ready_q;

  // Only an edge that also shows CFG_READY hands a word over
  wire cfg_take = CFG_VALID && cfg_ready_q;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cfg_ready_q <= 1'b0;
    end else begin
      cfg_ready_q <= crc_bus.ready && !cfg_take;
    end
  end

  assign CFG_READY = cfg_ready_q;

  // --------------------------------------------------------------
  // Checksum engine
  // --------------------------------------------------------------
  assign crc_bus.start = CFG_START;
  assign crc_bus.valid = cfg_take;
  assign crc_bus.last = CFG_LAST;
  assign crc_bus.word = CFG_WORD;

  smsr_crc16 u_crc (
    .clk(CLK),
    .nrst(NRST),
    .bus(crc_bus.eng)
  );

  logic [15:0] config_checksum_q;

  // R16: publish result after the pass over the CFG_LAST word
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      // R1: reset to all ones
      config_checksum_q <= `SMSR_RST_CHECKSUM;
    end else begin
      if (crc_bus.done_last) begin
        config_checksum_q <= crc_bus.crc;
      end
    end
  end

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------
  wire hit_checksum = (REG_ADDR == `SMSR_OFS_CHECKSUM);
  wire hit_misc = (REG_ADDR == `SMSR_OFS_MISC);
  wire hit_comp = (REG_ADDR == `SMSR_OFS_COMP);
  // R2: checksum in low 16 bits, upper byte zero
  wire [23:0] checksum_word = {8'h00, config_checksum_q};
  wire [23:0] rd_mux = hit_checksum ? checksum_word :
                       hit_misc ? misc_device_status_q :
                       hit_comp ? comparator_input_status_q : 24'h000000;

  logic [23:0] rdata_q;
  logic rvalid_q;
  logic wack_q;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rdata_q <= 24'h000000;
      rvalid_q <= 1'b0;
      wack_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD;
      // R14: writes acknowledged, contents untouched
      wack_q <= REG_WR;
      if (REG_RD) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign REG_WACK = wack_q;

endmodule
`default_nettype wire

// ---- hw/smsr_defines.svh ----
// Functional notes
// R1: The checksum field is read-only, holds a CRC-16-CCITT over the configuration and resets to all ones.
// R2: The checksum sits in bits 15 to 0 with bit 0 least significant, and bits 23 to 16 read zero.
// R3: The host may recompute the checksum over what it wrote and compare it with the value read back.
// R4: Bit 12 of the misc status word shows the converter self-diagnostic error and is zero otherwise.
// R5: Bits 11 and 10 show an abnormal current sink on inputs 3 and 2, reading zero when operational.
// R6: Bits 9 and 8 show an abnormal current source on inputs 1 and 0, reading zero when operational.
// R7: Bits 7-6 read 0 below the low threshold, 1 between the thresholds and 2 at or above the high one, never 3.
// R8: Bits 5-4 use the same three-level code against their own pair of thresholds.
// R9: Bit 3 reads one while the supply is below the under-voltage threshold.
// R10: Bit 2 reads one while the supply is above the over-voltage threshold.
// R11: Bit 1 reads one while the junction is above the warning temperature.
// R12: Bit 0 reads one while the junction is above the shutdown temperature.
// R13: Comparator status bit n reads one when input n is in comparator mode and above its threshold.
// R14: All three registers are read-only and writes leave them unchanged.
// R15: The misc status word tracks live conditions and latches nothing.
// R16: Every configuration write triggers a fresh checksum over the current settings. Here only a CFG_START word restarts it; CFG_LAST publishes it.
// R17: Reset returns every register to its default and restarts the state machines.
`ifndef SMSR_DEFINES_SVH
`define SMSR_DEFINES_SVH

`define SMSR_OFS_CHECKSUM 6'h03
`define SMSR_OFS_MISC 6'h04
`define SMSR_OFS_COMP 6'h05

`define SMSR_RST_CHECKSUM 16'hFFFF
`define SMSR_RST_MISC 24'h000000
`define SMSR_RST_COMP 24'h000000

`define SMSR_CRC_POLY 16'h1021
`define SMSR_CFG_BITS 5'h18
`define SMSR_CNT_LAST 5'h00

`define SMSR_BIT_ADC_DIAG 12
`define SMSR_BIT_SINK3 11
`define SMSR_BIT_SINK2 10
`define SMSR_BIT_SOURCE1 9
`define SMSR_BIT_SOURCE0 8
`define SMSR_POS_WIN_B 6
`define SMSR_POS_WIN_A 4
`define SMSR_BIT_UV 3
`define SMSR_BIT_OV 2
`define SMSR_BIT_TW 1
`define SMSR_BIT_TSD 0

`define SMSR_WIN_BELOW 2'h0
`define SMSR_WIN_MID 2'h1
`define SMSR_WIN_ABOVE 2'h2

`define SMSR_NUM_ASYNC 37

`endif

// ---- hw/smsr_pkg.sv ----
package smsr_pkg;

  typedef logic [23:0] smsr_word_t;
  typedef logic [15:0] smsr_crc_t;

  typedef enum logic [1:0] {
    SMSR_CRC_IDLE = 2'b01,
    SMSR_CRC_SHIFT = 2'b10
  } smsr_crc_state_e;

endpackage

// ---- hw/smsr_crc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface smsr_crc_if;
  logic start;
  logic valid;
  logic last;
  smsr_pkg::smsr_word_t word;
  logic ready;
  logic done_last;
  smsr_pkg::smsr_crc_t crc;

  modport ctrl (output start, output valid, output last, output word, input ready, input done_last, input crc);
  modport eng (input start, input valid, input last, input word, output ready, output done_last, output crc);
endinterface
`default_nettype wire

// ---- hw/smsr_crc16.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "smsr_defines.svh"
module smsr_crc16 (
  input wire logic clk,
  input wire logic nrst,
  smsr_crc_if.eng bus
);

  smsr_pkg::smsr_crc_state_e state_q;
  smsr_pkg::smsr_word_t shreg_q;
  smsr_pkg::smsr_crc_t crc_q;
  logic [4:0] cnt_q;
  logic last_q;
  logic done_q;

  // --------------------------------------------------------------
  // Bit-serial CRC, MSB first
  // --------------------------------------------------------------
  wire take = bus.valid && (state_q == smsr_pkg::SMSR_CRC_IDLE);
  wire [15:0] crc_base = bus.start ? `SMSR_RST_CHECKSUM : crc_q;
  wire feedback = crc_q[15] ^ shreg_q[23];
  wire [15:0] crc_step = {crc_q[14:0], 1'b0} ^ (feedback ? `SMSR_CRC_POLY : 16'h0000);
  wire final_bit = (state_q == smsr_pkg::SMSR_CRC_SHIFT) && (cnt_q == `SMSR_CNT_LAST);

  // R17: restart engine
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= smsr_pkg::SMSR_CRC_IDLE;
      shreg_q <= 24'h000000;
      crc_q <= `SMSR_RST_CHECKSUM;
      cnt_q <= 5'h00;
      last_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= final_bit && last_q;
      case (state_q)
        smsr_pkg::SMSR_CRC_IDLE: begin
          if (bus.start) begin
            crc_q <= crc_base;
          end
          if (take) begin
            shreg_q <= bus.word;
            last_q <= bus.last;
            cnt_q <= `SMSR_CFG_BITS - 5'h01;
            state_q <= smsr_pkg::SMSR_CRC_SHIFT;
          end
        end
        smsr_pkg::SMSR_CRC_SHIFT: begin
          // R1: CCITT polynomial step
          crc_q <= crc_step;
          shreg_q <= {shreg_q[22:0], 1'b0};
          cnt_q <= cnt_q - 5'h01;
          if (final_bit) begin
            state_q <= smsr_pkg::SMSR_CRC_IDLE;
          end
        end
        default: begin
          state_q <= smsr_pkg::SMSR_CRC_IDLE;
        end
      endcase
    end
  end

  assign bus.ready = (state_q == smsr_pkg::SMSR_CRC_IDLE);
  assign bus.done_last = done_q;
  assign bus.crc = crc_q;

endmodule
`default_nettype wire

// ---- tb/smsr_status_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module smsr_status_regs_chk (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [5:0] REG_ADDR,
  input wire logic [23:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic REG_WACK,
  input wire logic CFG_VALID,
  input wire logic CFG_READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ----
  // Checks
  // ----
  rd_answer_a: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
  rd_only_a: assert property (!REG_RD |=> !REG_RVALID) else $error("stray read valid");
  wr_ack_a: assert property (REG_WACK == $past(REG_WR)) else $error("write ack mismatch");
  rdata_hold_a: assert property (!$past(REG_RD) |-> $stable(REG_RDATA)) else $error("data moved");
  crc_resv_a: assert property (REG_RVALID && $past(REG_ADDR) == 6'h03 |-> REG_RDATA[23:16] == 8'h00)
    else $error("checksum upper bits set");
  misc_resv_a: assert property (REG_RVALID && $past(REG_ADDR) == 6'h04 |-> REG_RDATA[23:13] == 11'h000)
    else $error("misc reserved bits set");
  win_code_a: assert property (REG_RVALID && $past(REG_ADDR) == 6'h04 |->
    REG_RDATA[7:6] != 2'h3 && REG_RDATA[5:4] != 2'h3) else $error("window code 3");
  cfg_busy_a: assert property (CFG_VALID && CFG_READY |=> !CFG_READY [*8]) else $error("engine not busy");
  cover property (REG_RD && REG_ADDR == 6'h03);
  cover property (REG_WR);
  cover property (CFG_VALID && CFG_READY);
endmodule
bind smsr_status_regs smsr_status_regs_chk u_chk (.CLK(CLK), .NRST(NRST), .REG_RD(REG_RD), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_WACK(REG_WACK),
  .CFG_VALID(CFG_VALID), .CFG_READY(CFG_READY));
`default_nettype wire

// ---- tb/smsr_cfg_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module smsr_cfg_src (
  input wire logic clk,
  output logic cfg_start,
  output logic cfg_valid,
  output logic cfg_last,
  output logic [23:0] cfg_word,
  input wire logic cfg_ready,
  output logic [15:0] ref_crc
);
  initial begin
    cfg_start = 1'b0;
    cfg_valid = 1'b0;
    cfg_last = 1'b0;
    cfg_word = 24'h000000;
    ref_crc = 16'hFFFF;
  end
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [23:0] w);
    for (int b = 23; b >= 0; b--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  task automatic send(input logic [23:0] w, input logic s, input logic l, output logic ok);
    int n;
    @(negedge clk);
    cfg_word = w;
    cfg_start = s;
    cfg_last = l;
    cfg_valid = 1'b1;
    n = 0;
    while (!cfg_ready && n < 100) begin
      @(negedge clk);
      n++;
    end
    ok = cfg_ready;
    @(negedge clk);
    cfg_valid = 1'b0;
    cfg_start = 1'b0;
    cfg_last = 1'b0;
    cfg_word = ~w;
  endtask
  task automatic replay(input logic [23:0] a, input logic [23:0] b, output logic ok);
    logic ok2;
    ref_crc = fold(fold(16'hFFFF, a), b);
    send(a, 1'b1, 1'b0, ok);
    send(b, 1'b0, 1'b1, ok2);
    ok = ok & ok2;
  endtask
endmodule
`default_nettype wire

// ---- tb/smsr_status_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module smsr_status_regs_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [12:0] mon = 13'h0000;
  logic [23:0] sel = 24'h000000;
  logic [23:0] above = 24'h000000;
  logic [23:0] rdata, c_word, exp;
  logic rvalid, wack, c_start, c_valid, c_last, c_ready, ok;
  logic [15:0] ref_crc;
  int err_count = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  smsr_status_regs DUT (.CLK(clk), .NRST(nrst), .REG_RD(rd), .REG_WR(wr), .REG_ADDR(addr), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .REG_WACK(wack), .CFG_START(c_start), .CFG_VALID(c_valid), .CFG_LAST(c_last),
    .CFG_WORD(c_word), .CFG_READY(c_ready), .COMP_SEL(sel), .ADC_DIAG_ERR(mon[12]), .SINK_FAULT(mon[11:10]),
    .SOURCE_FAULT(mon[9:8]), .WIN_B_ABOVE_HIGH(mon[7]), .WIN_B_ABOVE_LOW(mon[6]), .WIN_A_ABOVE_HIGH(mon[5]),
    .WIN_A_ABOVE_LOW(mon[4]), .UNDERVOLTAGE(mon[3]), .OVERVOLTAGE(mon[2]), .OVER_WARNING_TEMP(mon[1]),
    .OVER_SHUTDOWN_TEMP(mon[0]), .COMP_ABOVE(above));
  smsr_cfg_src src (.clk(clk), .cfg_start(c_start), .cfg_valid(c_valid), .cfg_last(c_last),
    .cfg_word(c_word), .cfg_ready(c_ready), .ref_crc(ref_crc));
  // ----
  // Tasks
  // ----
  task automatic final_report();
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [23:0] want);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk({23'h000000, rvalid}, 24'h000001);
    chk(rdata, want);
  endtask
  task automatic wrc(input logic [5:0] a);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    @(negedge clk);
    wr = 1'b0;
    chk({23'h000000, wack}, 24'h000001);
  endtask
  function automatic logic [1:0] win(input logic h, input logic l);
    return h ? 2'h2 : (l ? 2'h1 : 2'h0);
  endfunction
  // ----
  // Sequence
  // ----
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    rdc(6'h03, 24'h00FFFF);
    rdc(6'h04, 24'h000000);
    rdc(6'h05, 24'h000000);
    rdc(6'h3F, 24'h000000);
    for (int i = 0; i < 14; i++) begin
      mon = (i < 13) ? 13'h0001 << i : 13'h1FFF;
      exp = {11'h000, mon[12:8], win(mon[7], mon[6]), win(mon[5], mon[4]), mon[3:0]};
      repeat (4) @(negedge clk);
      rdc(6'h04, exp);
    end
    wrc(6'h04);
    rdc(6'h04, exp);
    mon = 13'h0000;
    repeat (4) @(negedge clk);
    rdc(6'h04, 24'h000000);
    sel = 24'h800001;
    above = 24'hFFFFFF;
    repeat (4) @(negedge clk);
    rdc(6'h05, 24'h800001);
    sel = 24'hFFFFFF;
    above = 24'hA5A5A5;
    repeat (4) @(negedge clk);
    wrc(6'h05);
    rdc(6'h05, 24'hA5A5A5);
    for (int k = 0; k < 2; k++) begin
      src.replay(k ? 24'h000000 : 24'h123456, k ? 24'hFFFFFF : 24'hEDCBA9, ok);
      chk({23'h000000, ok}, 24'h000001);
      repeat (30) @(negedge clk);
      wrc(6'h03);
      rdc(6'h03, {8'h00, ref_crc});
    end
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    rdc(6'h03, 24'h00FFFF);
    rdc(6'h05, 24'hA5A5A5);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
